// file: core/dual_timer.sv
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "dual_timer_consts.svh"

module dual_timer (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_ext_in_a,
    input wire logic i_ext_in_b,
    input wire logic i_status_out_a,
    input wire logic i_status_out_b,
    output logic o_ext_out_a,
    output logic o_ext_out_b,
    output logic o_wdt_reset,
    output logic [1:0] o_irq_pending
);

    // ****************************************
    // Bus slave
    // ****************************************
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
    logic [7:0] loc_addr;
    logic sel_ch;
    logic sel_hit;
    dual_timer_pkg::reg_sel_e sel_reg;
    logic wr_fire;
    logic [31:0] rd_word [2];

    assign loc_addr = i_paddr & ~`TMR_CH1_BASE;
    assign sel_ch = i_paddr[5];

    always_comb begin
        sel_hit = 1'b1;
        sel_reg = dual_timer_pkg::REG_CTRL;
        if (i_paddr[7:6] != 2'h0) begin
            sel_hit = 1'b0;
        end else if (loc_addr == `TMR_OFF_CTRL) begin
            sel_reg = dual_timer_pkg::REG_CTRL;
        end else if (loc_addr == `TMR_OFF_RELOAD) begin
            sel_reg = dual_timer_pkg::REG_RELOAD;
        end else if (loc_addr == `TMR_OFF_COUNT) begin
            sel_reg = dual_timer_pkg::REG_COUNT;
        end else if (loc_addr == `TMR_OFF_PRE_RELOAD) begin
            sel_reg = dual_timer_pkg::REG_PRE_RELOAD;
        end else if (loc_addr == `TMR_OFF_PRE_COUNT) begin
            sel_reg = dual_timer_pkg::REG_PRE_COUNT;
        end else begin
            sel_hit = 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else if (i_ce) begin
            pready_reg <= i_psel & ~i_penable;
            pslverr_reg <= i_psel & ~i_penable & ~sel_hit;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            prdata_reg <= 32'h0000_0000;
        end else if (i_ce && i_psel && !i_penable && !i_pwrite) begin
            prdata_reg <= sel_hit ? rd_word[sel_ch] : 32'h0000_0000;
        end
    end

    assign wr_fire = i_psel & i_penable & i_pwrite & pready_reg & sel_hit;
    assign o_pready = pready_reg;
    assign o_pslverr = pslverr_reg;
    assign o_prdata = prdata_reg;

    // ****************************************
    // Input pin synchronisers
    // ****************************************
    logic [1:0] in_meta_reg;
    logic [1:0] in_sync_reg;

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            in_meta_reg <= 2'h0;
            in_sync_reg <= 2'h0;
        end else if (i_ce) begin
            in_meta_reg <= {i_ext_in_b, i_ext_in_a};
            in_sync_reg <= in_meta_reg;
        end
    end

    // ****************************************
    // Timer channels
    // ****************************************
    logic [`CTL_WIDTH-1:0] ctrl_reg [2];
    logic [15:0] reload_value_reg [2];
    logic [15:0] count_value_reg [2];
    logic [7:0] prescale_reload_reg [2];
    logic [7:0] prescale_count_reg [2];
    logic irq_pending_flag_reg [2];
    logic [15:0] width_reg [2];
    logic run_reg [2];
    logic square_reg [2];
    logic div2_reg [2];
    logic tick_clock_reg [2];
    logic in_tk_reg [2];
    logic in_prev_reg [2];
    logic underflow [2];
    logic wdt_fire [2];
    logic pin_level [2];
    logic drives_a [2];
    logic drives_b [2];

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_ch
            logic wr_ch;
            logic trig;
            logic tick_en;
            logic enabled;
            logic edge_ev;
            logic asserted;
            logic dec;
            logic act;
            dual_timer_pkg::mode_e mode;

            assign wr_ch = wr_fire && (sel_ch == 1'(gi));
            assign trig = wr_ch && (sel_reg == dual_timer_pkg::REG_COUNT);
            assign mode = dual_timer_pkg::mode_e'(ctrl_reg[gi][`CTL_MODE_MSB:`CTL_MODE_LSB]);
            assign enabled = ctrl_reg[gi][`CTL_ENABLE];
            assign tick_en = enabled && div2_reg[gi] && (prescale_count_reg[gi] == 8'h00)
                && !tick_clock_reg[gi];
            assign edge_ev = tick_en && (
                (ctrl_reg[gi][`CTL_EDGE_RISE] && in_tk_reg[gi] && !in_prev_reg[gi]) ||
                (ctrl_reg[gi][`CTL_EDGE_FALL] && !in_tk_reg[gi] && in_prev_reg[gi]));
            assign asserted = in_tk_reg[gi] == ctrl_reg[gi][`CTL_POL_HIGH];

            always_comb begin
                case (mode)
                    dual_timer_pkg::MODE_SQUARE: dec = tick_en;
                    dual_timer_pkg::MODE_ONE_SHOT: dec = tick_en && run_reg[gi];
                    dual_timer_pkg::MODE_PWM8: dec = tick_en;
                    dual_timer_pkg::MODE_PWM16: dec = tick_en;
                    dual_timer_pkg::MODE_PULSE_TRAIN: dec = tick_en && run_reg[gi];
                    dual_timer_pkg::MODE_EDGE_PULSE: dec = edge_ev && run_reg[gi];
                    dual_timer_pkg::MODE_WDT_SOFT: dec = tick_en;
                    dual_timer_pkg::MODE_WDT_PIN: dec = tick_en && !edge_ev;
                    dual_timer_pkg::MODE_PULSE_WIDTH: dec = tick_en && run_reg[gi];
                    dual_timer_pkg::MODE_PERIOD: dec = tick_en && run_reg[gi] && !edge_ev;
                    dual_timer_pkg::MODE_EDGE_COUNT: dec = edge_ev;
                    dual_timer_pkg::MODE_EDGE_WINDOW: dec = edge_ev && run_reg[gi];
                    default: dec = 1'b0;
                endcase
            end

            assign underflow[gi] = dec && (count_value_reg[gi] == 16'h0000);
            assign wdt_fire[gi] = underflow[gi] && ((mode == dual_timer_pkg::MODE_WDT_SOFT) ||
                (mode == dual_timer_pkg::MODE_WDT_PIN));

            always_comb begin
                case (mode)
                    dual_timer_pkg::MODE_SQUARE: act = square_reg[gi];
                    dual_timer_pkg::MODE_ONE_SHOT: act = run_reg[gi];
                    dual_timer_pkg::MODE_PWM8: act = count_value_reg[gi][7:0] < width_reg[gi][7:0];
                    dual_timer_pkg::MODE_PWM16: act = count_value_reg[gi] < width_reg[gi];
                    dual_timer_pkg::MODE_PULSE_TRAIN: act = run_reg[gi] && tick_clock_reg[gi];
                    dual_timer_pkg::MODE_EDGE_PULSE: act = run_reg[gi];
                    default: act = 1'b0;
                endcase
            end
            assign pin_level[gi] = act ~^ ctrl_reg[gi][`CTL_POL_HIGH];
            assign drives_a[gi] = enabled && ctrl_reg[gi][`CTL_OUT_EN] && !ctrl_reg[gi][`CTL_OUT_SEL];
            assign drives_b[gi] = enabled && ctrl_reg[gi][`CTL_OUT_EN] && ctrl_reg[gi][`CTL_OUT_SEL];

            // Software registers
            always_ff @(posedge i_clk_sys or posedge i_rst) begin
                if (i_rst) begin
                    ctrl_reg[gi] <= `RST_CTRL;
                    reload_value_reg[gi] <= `RST_RELOAD;
                    prescale_reload_reg[gi] <= `RST_PRE_RELOAD;
                end else if (i_ce && wr_ch) begin
                    if (sel_reg == dual_timer_pkg::REG_CTRL) begin
                        ctrl_reg[gi] <= i_pwdata[`CTL_WIDTH-1:0];
                    end else if (sel_reg == dual_timer_pkg::REG_RELOAD) begin
                        reload_value_reg[gi] <= i_pwdata[15:0];
                    end else if (sel_reg == dual_timer_pkg::REG_PRE_RELOAD) begin
                        prescale_reload_reg[gi] <= i_pwdata[7:0];
                    end
                end
            end

            always_ff @(posedge i_clk_sys or posedge i_rst) begin
                if (i_rst) begin
                    irq_pending_flag_reg[gi] <= 1'b0;
                end else if (i_ce) begin
                    if (underflow[gi] ||
                        (tick_en && run_reg[gi] && mode == dual_timer_pkg::MODE_PULSE_WIDTH
                            && !asserted) ||
                        (edge_ev && run_reg[gi] && mode == dual_timer_pkg::MODE_PERIOD)) begin
                        irq_pending_flag_reg[gi] <= 1'b1;
                    end else if (wr_ch && sel_reg == dual_timer_pkg::REG_PRE_RELOAD
                        && i_pwdata[`PRL_IP_BIT]) begin
                        irq_pending_flag_reg[gi] <= 1'b0;
                    end
                end
            end

            always_ff @(posedge i_clk_sys or posedge i_rst) begin
                if (i_rst) begin
                    div2_reg[gi] <= 1'b0;
                    tick_clock_reg[gi] <= 1'b0;
                    prescale_count_reg[gi] <= 8'h00;
                end else if (i_ce) begin
                    div2_reg[gi] <= enabled ? !div2_reg[gi] : 1'b0;
                    // Tick phase keeps running through a counter reload
                    if (enabled && div2_reg[gi] && prescale_count_reg[gi] == 8'h00) begin
                        tick_clock_reg[gi] <= !tick_clock_reg[gi];
                    end
                    if ((wr_ch && sel_reg == dual_timer_pkg::REG_PRE_COUNT) || trig ||
                        underflow[gi]) begin
                        prescale_count_reg[gi] <= prescale_reload_reg[gi];
                    end else if (enabled && div2_reg[gi]) begin
                        if (prescale_count_reg[gi] == 8'h00) begin
                            prescale_count_reg[gi] <= prescale_reload_reg[gi];
                        end else begin
                            prescale_count_reg[gi] <= prescale_count_reg[gi] - 8'h01;
                        end
                    end
                end
            end

            always_ff @(posedge i_clk_sys or posedge i_rst) begin
                if (i_rst) begin
                    in_tk_reg[gi] <= 1'b0;
                    in_prev_reg[gi] <= 1'b0;
                end else if (i_ce && tick_en) begin
                    in_tk_reg[gi] <= ctrl_reg[gi][`CTL_IN_SEL] ? in_sync_reg[1] : in_sync_reg[0];
                    in_prev_reg[gi] <= in_tk_reg[gi];
                end
            end

            always_ff @(posedge i_clk_sys or posedge i_rst) begin
                if (i_rst) begin
                    count_value_reg[gi] <= 16'h0000;
                    width_reg[gi] <= 16'h0000;
                    run_reg[gi] <= 1'b0;
                    square_reg[gi] <= 1'b0;
                end else if (i_ce) begin
                    if (trig) begin
                        width_reg[gi] <= reload_value_reg[gi];
                        run_reg[gi] <= (mode != dual_timer_pkg::MODE_PULSE_WIDTH) &&
                            (mode != dual_timer_pkg::MODE_PERIOD);
                        if (mode == dual_timer_pkg::MODE_PWM8) begin
                            count_value_reg[gi] <= `PWM8_PERIOD_TOP;
                        end else if (mode == dual_timer_pkg::MODE_PWM16) begin
                            count_value_reg[gi] <= `PWM16_PERIOD_TOP;
                        end else begin
                            count_value_reg[gi] <= reload_value_reg[gi];
                        end
                    end else if (underflow[gi]) begin
                        width_reg[gi] <= reload_value_reg[gi];
                        square_reg[gi] <= !square_reg[gi];
                        if (mode == dual_timer_pkg::MODE_PWM8) begin
                            count_value_reg[gi] <= `PWM8_PERIOD_TOP;
                        end else if (mode == dual_timer_pkg::MODE_PWM16) begin
                            count_value_reg[gi] <= `PWM16_PERIOD_TOP;
                        end else begin
                            count_value_reg[gi] <= reload_value_reg[gi];
                        end
                        if (mode == dual_timer_pkg::MODE_ONE_SHOT ||
                            mode == dual_timer_pkg::MODE_PULSE_TRAIN ||
                            mode == dual_timer_pkg::MODE_EDGE_PULSE ||
                            mode == dual_timer_pkg::MODE_EDGE_WINDOW) begin
                            run_reg[gi] <= 1'b0;
                        end
                    end else if (mode == dual_timer_pkg::MODE_WDT_PIN && edge_ev) begin
                        count_value_reg[gi] <= reload_value_reg[gi];
                    end else if (mode == dual_timer_pkg::MODE_PULSE_WIDTH && tick_en) begin
                        if (!run_reg[gi] && asserted) begin
                            count_value_reg[gi] <= reload_value_reg[gi];
                            run_reg[gi] <= 1'b1;
                        end else if (run_reg[gi] && !asserted) begin
                            run_reg[gi] <= 1'b0;
                        end else if (dec) begin
                            count_value_reg[gi] <= count_value_reg[gi] - 16'h0001;
                        end
                    end else if (mode == dual_timer_pkg::MODE_PERIOD && edge_ev) begin
                        if (!run_reg[gi]) begin
                            count_value_reg[gi] <= reload_value_reg[gi];
                        end
                        run_reg[gi] <= !run_reg[gi];
                    end else if (mode == dual_timer_pkg::MODE_EDGE_WINDOW &&
                        underflow[1 - gi]) begin
                        run_reg[gi] <= 1'b0;
                    end else if (dec) begin
                        count_value_reg[gi] <= count_value_reg[gi] - 16'h0001;
                    end
                end
            end

            assign rd_word[gi] =
                (sel_reg == dual_timer_pkg::REG_CTRL) ? {21'h000000, ctrl_reg[gi]} :
                (sel_reg == dual_timer_pkg::REG_RELOAD) ? {16'h0000, reload_value_reg[gi]} :
                (sel_reg == dual_timer_pkg::REG_COUNT) ? {16'h0000, count_value_reg[gi]} :
                (sel_reg == dual_timer_pkg::REG_PRE_RELOAD) ?
                    {16'h0000, irq_pending_flag_reg[gi], 7'h00, prescale_reload_reg[gi]} :
                {24'h000000, prescale_count_reg[gi]};
        end
    endgenerate

    // ****************************************
    // Output pins and watchdog reset
    // ****************************************
    logic out_a_reg;
    logic out_b_reg;
    logic wdt_reset_reg;

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            out_a_reg <= 1'b0;
            out_b_reg <= 1'b0;
            wdt_reset_reg <= 1'b0;
        end else if (i_ce) begin
            if (drives_a[0]) begin
                out_a_reg <= pin_level[0];
            end else if (drives_a[1]) begin
                out_a_reg <= pin_level[1];
            end else begin
                out_a_reg <= i_status_out_a;
            end
            if (drives_b[0]) begin
                out_b_reg <= pin_level[0];
            end else if (drives_b[1]) begin
                out_b_reg <= pin_level[1];
            end else begin
                out_b_reg <= i_status_out_b;
            end
            wdt_reset_reg <= wdt_fire[0] | wdt_fire[1];
        end
    end

    assign o_ext_out_a = out_a_reg;
    assign o_ext_out_b = out_b_reg;
    assign o_wdt_reset = wdt_reset_reg;
    assign o_irq_pending = {irq_pending_flag_reg[1], irq_pending_flag_reg[0]};

endmodule : dual_timer

// file: core/dual_timer_consts.svh
`ifndef DUAL_TIMER_CONSTS_SVH
`define DUAL_TIMER_CONSTS_SVH

// ****************************************
// Register byte offsets within one timer, and the base address of timer 1
// ****************************************
`define TMR_OFF_CTRL 8'h00
`define TMR_OFF_RELOAD 8'h04
`define TMR_OFF_COUNT 8'h08
`define TMR_OFF_PRE_RELOAD 8'h0C
`define TMR_OFF_PRE_COUNT 8'h10
`define TMR_CH1_BASE 8'h20

// ****************************************
// Control register fields
// ****************************************
`define CTL_MODE_LSB 0
`define CTL_MODE_MSB 3
`define CTL_ENABLE 4
`define CTL_EDGE_RISE 5
`define CTL_EDGE_FALL 6
`define CTL_POL_HIGH 7
`define CTL_IN_SEL 8
`define CTL_OUT_SEL 9
`define CTL_OUT_EN 10
`define CTL_WIDTH 11

// ****************************************
// Prescale reload register fields
// ****************************************
`define PRL_IP_BIT 15

// ****************************************
// Reset values and fixed counts
// ****************************************
`define RST_CTRL 11'h000
`define RST_RELOAD 16'hFFFF
`define RST_PRE_RELOAD 8'h00
`define PWM8_PERIOD_TOP 16'h00FF
`define PWM16_PERIOD_TOP 16'hFFFF

`endif

// file: core/dual_timer_pkg.sv
package dual_timer_pkg;

    typedef enum logic [3:0] {
        MODE_SQUARE = 4'h0,
        MODE_ONE_SHOT = 4'h1,
        MODE_PWM8 = 4'h2,
        MODE_PWM16 = 4'h3,
        MODE_PULSE_TRAIN = 4'h4,
        MODE_EDGE_PULSE = 4'h5,
        MODE_WDT_SOFT = 4'h6,
        MODE_WDT_PIN = 4'h7,
        MODE_PULSE_WIDTH = 4'h8,
        MODE_PERIOD = 4'h9,
        MODE_EDGE_COUNT = 4'hA,
        MODE_EDGE_WINDOW = 4'hB
    } mode_e;

    typedef enum logic [2:0] {
        REG_CTRL = 3'h0,
        REG_RELOAD = 3'h1,
        REG_COUNT = 3'h2,
        REG_PRE_RELOAD = 3'h3,
        REG_PRE_COUNT = 3'h4
    } reg_sel_e;

endpackage : dual_timer_pkg

// file: bench/dual_timer_chk.sv
`timescale 1ns/1ps
// ****************************************
// Bus and pin relations of the timer pair
// ****************************************
module dual_timer_chk (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic o_wdt_reset,
    input wire logic [1:0] o_irq_pending
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst || !i_ce);
    ready_after_setup_a: assert property (i_psel && !i_penable |=> o_pready)
        else $error("pready missing after setup");
    ready_one_cycle_a: assert property (o_pready |=> !o_pready)
        else $error("pready longer than one cycle");
    ready_cause_a: assert property (o_pready |-> $past(i_psel && !i_penable))
        else $error("pready without setup");
    err_with_ready_a: assert property (o_pslverr |-> o_pready)
        else $error("pslverr without pready");
    unmapped_err_a: assert property (i_psel && !i_penable && i_paddr[7:6] != 2'h0
        |=> o_pslverr && o_prdata == 32'h0) else $error("unmapped access not refused");
    ctrl_mapped_a: assert property (i_psel && !i_penable && i_paddr == 8'h00
        |=> !o_pslverr) else $error("control register refused");
    pre_count_width_a: assert property (i_psel && !i_penable && !i_pwrite
        && i_paddr == 8'h10 |=> o_prdata[31:8] == 24'h0) else $error("prescale too wide");
    wdt_pulse_a: assert property (o_wdt_reset |=> !o_wdt_reset)
        else $error("watchdog reset not a single pulse");
    pend_clear_a: assert property ($fell(o_irq_pending[0]) |-> $past(i_psel && i_penable
        && i_pwrite && i_paddr == 8'h0C && i_pwdata[15])) else $error("pending lost");
endmodule : dual_timer_chk

bind dual_timer dual_timer_chk u_chk (.i_clk_sys, .i_rst, .i_ce, .i_psel, .i_penable,
    .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .o_wdt_reset,
    .o_irq_pending);

// file: bench/pin_source.sv
`timescale 1ns/1ps
// ****************************************
// Outside world driving the input pins
// ****************************************
module pin_source (
    input wire logic i_clk,
    output logic o_in_a,
    output logic o_in_b
);
    initial begin
        o_in_a = 1'b0;
        o_in_b = 1'b0;
    end
    task automatic pulses(input int n);
        repeat (n) begin
            o_in_b <= 1'b1;
            repeat (40) @(posedge i_clk);
            o_in_b <= 1'b0;
            repeat (40) @(posedge i_clk);
        end
    endtask : pulses
endmodule : pin_source

// file: bench/dual_timer_test.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("ERROR %s exp %0h got %0h", n, e, g); end end
// ****************************************
// Register and pin scenarios
// ****************************************
module dual_timer_test;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, st_a = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rdata, prdata;
    logic rerr, pready, pslverr, in_a, in_b, out_a, wdt;
    logic [1:0] pend;
    int miscompares = 0, num_checks = 0, n, m;
    always #25 clk = ~clk;
    dual_timer u_dut (.i_clk_sys(clk), .i_rst(rst), .i_ce(1'b1), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_ext_in_a(in_a),
        .i_ext_in_b(in_b), .i_status_out_a(st_a), .i_status_out_b(1'b0),
        .o_ext_out_a(out_a), .o_ext_out_b(), .o_wdt_reset(wdt), .o_irq_pending(pend));
    pin_source u_src (.i_clk(clk), .o_in_a(in_a), .o_in_b(in_b));
    task automatic wrap_up;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            miscompares++;
            wrap_up();
        end
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        apb(1'b0, 8'h00, 32'h0); `CHK("ctrl_rst", 32'h0, rdata)
        apb(1'b0, 8'h04, 32'h0); `CHK("reload_rst", 32'h0000FFFF, rdata)
        apb(1'b0, 8'h2C, 32'h0); `CHK("pre_reload_rst", 32'h0, rdata)
        apb(1'b0, 8'h40, 32'h0); `CHK("unmapped_err", 1'b1, rerr)
        apb(1'b0, 8'h10, 32'h0); `CHK("pre_count_hi", 24'h0, rdata[31:8])
        apb(1'b1, 8'h24, 32'h00000123);
        apb(1'b0, 8'h04, 32'h0); `CHK("reload_indep", 32'h0000FFFF, rdata)
        apb(1'b1, 8'h28, 32'h00005555);
        apb(1'b0, 8'h28, 32'h0); `CHK("count_load", 32'h00000123, rdata)
        st_a <= 1'b1;
        apb(1'b1, 8'h04, 32'h00000003);
        `CHK("status_pass", 1'b1, out_a)
        apb(1'b1, 8'h00, 32'h00000491);
        apb(1'b1, 8'h08, 32'h0);
        repeat (3) @(posedge clk);
        apb(1'b1, 8'h08, 32'h0);
        m = 0;
        while (out_a === 1'b1 && m < 100) begin
            @(posedge clk);
            m++;
        end
        `CHK("shot_len", 1'b1, m >= 12 && m <= 24)
        `CHK("pin_after_shot", 1'b0, out_a)
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b0, 8'h0C, 32'h0); `CHK("pend_set", 1'b1, rdata[15])
        apb(1'b1, 8'h0C, 32'h00008000);
        apb(1'b0, 8'h0C, 32'h0); `CHK("pend_clr", 1'b0, rdata[15])
        apb(1'b1, 8'h24, 32'h0000FFFF);
        for (int k = 1; k < 4; k++) begin
            apb(1'b1, 8'h20, 32'h0000011A | (k << 5));
            apb(1'b1, 8'h28, 32'h0);
            u_src.pulses(5);
            repeat (30) @(posedge clk);
            apb(1'b0, 8'h28, 32'h0);
            `CHK("edge_count", 32'h0000FFFF - (k == 3 ? 10 : 5), rdata)
        end
        apb(1'b1, 8'h04, 32'h00000002);
        apb(1'b1, 8'h00, 32'h00000016);
        apb(1'b1, 8'h08, 32'h0);
        n = 0;
        while (wdt !== 1'b1 && n < 60) begin
            @(posedge clk);
            n++;
        end
        `CHK("wdt_fire", 1'b1, wdt)
        wrap_up();
    end
endmodule : dual_timer_test
